// ---- psg_map.svh ----
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: A 40 MHz clock on aclk.
// Notes:   Definitions only; included by every design file that needs them.
`ifndef PSG_MAP_SVH
`define PSG_MAP_SVH

`define PSG_CLK_MHZ      40
`define PSG_NPIN         8
`define PSG_NMC          64

// Register byte offsets.
`define PSG_OFF_CTRL     8'h00
`define PSG_OFF_STATUS   8'h04
`define PSG_OFF_RPWR_LO  8'h08
`define PSG_OFF_RPWR_HI  8'h0c
`define PSG_OFF_ISP      8'h10

// Control fields.
`define PSG_CTRL_PDEN    0
`define PSG_CTRL_SBEN    1
`define PSG_CTRL_JTAGEN  2
`define PSG_CTRL_KEEPEN  3
`define PSG_CTRL_RST     32'h0000_0004

// Programming command fields, write-one pulses.
`define PSG_ISP_START    0
`define PSG_ISP_DONE     1
`define PSG_ISP_ABORT    2

// Timing in ns and derived cycle counts.
`define PSG_IDLE_NS      400
`define PSG_IDLE_CYC     ((`PSG_IDLE_NS * `PSG_CLK_MHZ + 999) / 1000)
`define PSG_RESUME_NS    1000
`define PSG_RESUME_CYC   ((`PSG_RESUME_NS * `PSG_CLK_MHZ) / 1000)

`endif

// ---- psg_pkg.sv ----
// Purpose: Types shared by the power-state and programming-guard block.
// Assumes: Nothing beyond the map header.
// Notes:   State codes are left to the tools.
package psg_pkg;
	typedef enum logic [1:0] {PSG_RUN, PSG_STANDBY, PSG_PDOWN, PSG_RESUME} psg_pwr_t;
	typedef enum logic [1:0] {PSG_ISP_IDLE, PSG_ISP_PROG, PSG_ISP_LOCKED} psg_isp_t;
endpackage : psg_pkg

// ---- psg_reg_if.sv ----
// Purpose: Carries register strobes between the bus slave and the register file.
// Assumes: One write and one read at most in flight.
// Notes:   The register side answers hit flags and read data combinationally.
`timescale 1ns/100ps
`default_nettype none
interface psg_reg_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_hit;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_hit;
	modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		input wr_hit, rd_data, rd_hit);
	modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
		output wr_hit, rd_data, rd_hit);
endinterface : psg_reg_if
`default_nettype wire

// ---- psg_sync.sv ----
// Purpose: Three-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to aclk.
// Notes:   A change is taken once the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module psg_sync #(parameter int W = 1) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1, s2, s3, next_q;

	// Only stage two reads stage one.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q  <= '0;
		end else begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q  <= next_q;
		end
	end

	// A disagreeing pair keeps the old value, filtering one-cycle glitches.
	for (genvar i = 0; i < W; i++) begin : g_agree
		assign next_q[i] = (s2[i] == s3[i]) ? s3[i] : q[i];
	end
endmodule : psg_sync
`default_nettype wire

// ---- psg_axil.sv ----
// Purpose: AXI4-Lite slave that turns bus cycles into register strobes.
// Assumes: Address and data may arrive in either order.
// Notes:   Ready signals are low in the first cycle after reset.
`timescale 1ns/100ps
`default_nettype none
module psg_axil (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	psg_reg_if.bus           rb
);
	logic aw_full, w_full, next_aw_full, next_w_full, next_rvalid;
	wire  aw_take  = awvalid & awready;
	wire  w_take   = wvalid & wready;
	wire  ar_take  = arvalid & arready;
	wire  do_write = aw_full & w_full & ~bvalid;

	assign next_aw_full = do_write ? 1'b0 : (aw_full | aw_take);
	assign next_w_full  = do_write ? 1'b0 : (w_full | w_take);
	assign next_rvalid  = ar_take | (rvalid & ~rready);
	assign rb.wr_en     = do_write;
	assign rb.rd_addr   = araddr;

	// Write path: hold each half until both are in, then answer once.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= 2'h0;
			rb.wr_addr <= 8'h00;
			rb.wr_data <= 32'h0000_0000;
			rb.wr_strb <= 4'h0;
		end else begin
			aw_full <= next_aw_full;
			w_full  <= next_w_full;
			awready <= ~next_aw_full;
			wready  <= ~next_w_full;
			if (aw_take) rb.wr_addr <= awaddr;
			if (w_take) begin
				rb.wr_data <= wdata;
				rb.wr_strb <= wstrb;
			end
			if (do_write) begin
				bvalid <= 1'b1;
				bresp  <= rb.wr_hit ? 2'h0 : 2'h2;
			end else if (bready) bvalid <= 1'b0;
		end
	end

	// Read path: data is captured at the address handshake.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= 2'h0;
		end else begin
			arready <= ~next_rvalid;
			rvalid  <= next_rvalid;
			if (ar_take) begin
				rdata <= rb.rd_hit ? rb.rd_data : 32'h0000_0000;
				rresp <= rb.rd_hit ? 2'h0 : 2'h2;
			end
		end
	end
endmodule : psg_axil
`default_nettype wire

// ---- psg_top.sv ----
// Purpose: Power-state control and programming guard for a logic device.
// Assumes: 40 MHz aclk; pins and power-down inputs are asynchronous.
// Notes:   Registers are reached over AXI4-Lite.
`include "psg_map.svh"
`timescale 1ns/100ps
`default_nettype none
module psg_top import psg_pkg::*; (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    power_down_input_a,
	input  wire logic                    power_down_input_b,
	input  wire logic [`PSG_NPIN-1:0]    pin_in,
	output logic      [`PSG_NPIN-1:0]    pin_out,
	output logic      [`PSG_NPIN-1:0]    pin_oe_n,
	input  wire logic                    jtag_tck,
	input  wire logic                    jtag_tms,
	input  wire logic                    jtag_tdi,
	output logic                         jtag_tdo,
	output logic                         jtag_tdo_oe_n,
	input  wire logic [`PSG_NPIN-1:0]    core_out,
	input  wire logic [`PSG_NPIN-1:0]    core_oe,
	input  wire logic                    core_jtag_out,
	output logic      [`PSG_NPIN+2:0]    core_in,
	output logic                         core_hold,
	output logic                         core_standby,
	output logic      [`PSG_NMC-1:0]     mc_reduced_power
);
	//--------------------------------------------------------------
	// Bus slave and input synchronisers
	//--------------------------------------------------------------
	psg_reg_if rb ();
	logic [`PSG_NPIN+4:0] sync_q;
	logic [31:0]          ctrl;
	logic                 programmed, tdi_bit, tck_q;
	logic [7:0]           idle_cnt, resume_cnt;
	logic [`PSG_NPIN-1:0] pin_prev, core_prev;
	psg_pwr_t             pwr_state, next_pwr;
	psg_isp_t             isp_state, next_isp;

	psg_axil u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.rb      (rb)
	);

	psg_sync #(.W(`PSG_NPIN + 5)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({power_down_input_a, power_down_input_b, jtag_tck, jtag_tms,
			jtag_tdi, pin_in}),
		.q       (sync_q)
	);

	// Named views of the synchronised inputs.
	wire                 pd_a     = sync_q[`PSG_NPIN+4];
	wire                 pd_b     = sync_q[`PSG_NPIN+3];
	wire [2:0]           jtag_q   = sync_q[`PSG_NPIN+2:`PSG_NPIN];
	wire [`PSG_NPIN-1:0] pins_q   = sync_q[`PSG_NPIN-1:0];

	//--------------------------------------------------------------
	// Register decode
	//--------------------------------------------------------------
	// Byte-lane merge shared by the control and reduced-power registers.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) r[8*b +: 8] = data[8*b +: 8];
		end
		return r;
	endfunction : merge

	wire wr_ctrl = rb.wr_en && rb.wr_addr == `PSG_OFF_CTRL;
	wire wr_lo   = rb.wr_en && rb.wr_addr == `PSG_OFF_RPWR_LO;
	wire wr_hi   = rb.wr_en && rb.wr_addr == `PSG_OFF_RPWR_HI;
	wire wr_isp  = rb.wr_en && rb.wr_addr == `PSG_OFF_ISP && rb.wr_strb[0];
	wire isp_start = wr_isp && rb.wr_data[`PSG_ISP_START];
	wire isp_done  = wr_isp && rb.wr_data[`PSG_ISP_DONE];
	wire isp_abort = wr_isp && rb.wr_data[`PSG_ISP_ABORT];

	wire pd_en   = ctrl[`PSG_CTRL_PDEN];
	wire sb_en   = ctrl[`PSG_CTRL_SBEN];
	wire jtag_en = ctrl[`PSG_CTRL_JTAGEN];
	wire keep_ok = ctrl[`PSG_CTRL_KEEPEN] & programmed;

	assign rb.wr_hit = rb.wr_addr == `PSG_OFF_CTRL || rb.wr_addr == `PSG_OFF_RPWR_LO
		|| rb.wr_addr == `PSG_OFF_RPWR_HI || rb.wr_addr == `PSG_OFF_ISP
		|| rb.wr_addr == `PSG_OFF_STATUS;
	assign rb.rd_hit = rb.rd_addr == `PSG_OFF_CTRL || rb.rd_addr == `PSG_OFF_RPWR_LO
		|| rb.rd_addr == `PSG_OFF_RPWR_HI || rb.rd_addr == `PSG_OFF_ISP
		|| rb.rd_addr == `PSG_OFF_STATUS;

	// Status shows the block's own state; the command word reads as zero.
	wire [31:0] status = {26'h0, programmed, isp_state == PSG_ISP_LOCKED,
		isp_state == PSG_ISP_PROG, pwr_state == PSG_RESUME,
		pwr_state == PSG_STANDBY, pwr_state == PSG_PDOWN};
	assign rb.rd_data =
		(rb.rd_addr == `PSG_OFF_CTRL)    ? ctrl :
		(rb.rd_addr == `PSG_OFF_STATUS)  ? status :
		(rb.rd_addr == `PSG_OFF_RPWR_LO) ? mc_reduced_power[31:0] :
		(rb.rd_addr == `PSG_OFF_RPWR_HI) ? mc_reduced_power[63:32] : 32'h0000_0000;

	// Configuration registers; per-macrocell bits drive the fabric directly.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl             <= `PSG_CTRL_RST;
			mc_reduced_power <= '0;
		end else begin
			if (wr_ctrl) ctrl <= merge(ctrl, rb.wr_data, rb.wr_strb) & 32'h0000_000f;
			if (wr_lo) mc_reduced_power[31:0] <= merge(mc_reduced_power[31:0],
				rb.wr_data, rb.wr_strb);
			if (wr_hi) mc_reduced_power[63:32] <= merge(mc_reduced_power[63:32],
				rb.wr_data, rb.wr_strb);
		end
	end

	//--------------------------------------------------------------
	// Power state machine
	//--------------------------------------------------------------
	wire pd_req   = pd_en & (pd_a | pd_b);
	wire activity = (pins_q != pin_prev) || (core_out != core_prev);
	wire freeze   = pwr_state == PSG_PDOWN;

	// Resume is only a status window; outputs are released at once.
	always_comb begin
		next_pwr = pwr_state;
		case (pwr_state)
			PSG_RUN: begin
				if (pd_req) next_pwr = PSG_PDOWN;
				else if (sb_en && idle_cnt == 8'(`PSG_IDLE_CYC)) next_pwr = PSG_STANDBY;
			end
			PSG_STANDBY: begin
				if (pd_req) next_pwr = PSG_PDOWN;
				else if (activity || !sb_en) next_pwr = PSG_RUN;
			end
			PSG_PDOWN: begin
				if (!pd_req) next_pwr = PSG_RESUME;
			end
			PSG_RESUME: begin
				if (pd_req) next_pwr = PSG_PDOWN;
				else if (resume_cnt == 8'(`PSG_RESUME_CYC)) next_pwr = PSG_RUN;
			end
			default: next_pwr = PSG_RUN;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_state    <= PSG_RUN;
			idle_cnt     <= 8'h00;
			resume_cnt   <= 8'h00;
			pin_prev     <= '0;
			core_prev    <= '0;
			core_hold    <= 1'b0;
			core_standby <= 1'b0;
		end else begin
			pwr_state    <= next_pwr;
			pin_prev     <= pins_q;
			core_prev    <= core_out;
			idle_cnt     <= (activity || pwr_state != PSG_RUN) ? 8'h00
				: (idle_cnt == 8'(`PSG_IDLE_CYC)) ? idle_cnt : idle_cnt + 8'h01;
			resume_cnt   <= (pwr_state == PSG_RESUME) ? resume_cnt + 8'h01 : 8'h00;
			core_hold    <= next_pwr == PSG_PDOWN;
			core_standby <= next_pwr == PSG_STANDBY;
		end
	end

	//--------------------------------------------------------------
	// Programming guard
	//--------------------------------------------------------------
	// Losing the test port mid-session counts as an interruption.
	always_comb begin
		next_isp = isp_state;
		case (isp_state)
			PSG_ISP_IDLE, PSG_ISP_LOCKED: begin
				if (isp_start && jtag_en) next_isp = PSG_ISP_PROG;
			end
			PSG_ISP_PROG: begin
				if (isp_abort || !jtag_en) next_isp = PSG_ISP_LOCKED;
				else if (isp_done) next_isp = PSG_ISP_IDLE;
			end
			default: next_isp = PSG_ISP_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			isp_state  <= PSG_ISP_IDLE;
			programmed <= 1'b0;
		end else begin
			isp_state  <= next_isp;
			if (isp_state == PSG_ISP_PROG && next_isp == PSG_ISP_IDLE) programmed <= 1'b1;
		end
	end

	//--------------------------------------------------------------
	// Pin and core-input stage
	//--------------------------------------------------------------
	// Pins hold in power-down, float when locked, keep level if kept.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out  <= '0;
			pin_oe_n <= '1;
			core_in  <= '0;
		end else if (!freeze) begin
			core_in <= {jtag_en ? 3'h0 : jtag_q, pins_q};
			if (isp_state == PSG_ISP_LOCKED) begin
				pin_oe_n <= '1;
			end else if (isp_state == PSG_ISP_PROG) begin
				if (!keep_ok) pin_oe_n <= '1;
			end else begin
				pin_out  <= core_out;
				pin_oe_n <= ~core_oe;
			end
		end
	end

	// Bypass path on the test port; the pin goes to user logic when off.
	wire tck_rise = jtag_q[2] & ~tck_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tck_q         <= 1'b0;
			tdi_bit       <= 1'b0;
			jtag_tdo      <= 1'b0;
			jtag_tdo_oe_n <= 1'b1;
		end else if (!freeze) begin
			tck_q         <= jtag_q[2];
			if (tck_rise) tdi_bit <= jtag_q[0];
			jtag_tdo      <= jtag_en ? tdi_bit : core_jtag_out;
			jtag_tdo_oe_n <= (isp_state == PSG_ISP_LOCKED);
		end
	end

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_frozen2;
		freeze ##1 freeze;
	endsequence
	sequence s_abort_prog;
		isp_state == PSG_ISP_PROG && (isp_abort || !jtag_en);
	endsequence

	a_pd_entry: assert property ((pwr_state == PSG_RUN || pwr_state == PSG_STANDBY)
		&& pd_en && (pd_a || pd_b) |=> freeze && core_hold)
		else $error("power-down not entered");
	a_pd_option_off: assert property (!pd_en |=> !freeze)
		else $error("power-down without option");
	a_hold_outputs: assert property (s_frozen2 |-> $stable(pin_out) && $stable(pin_oe_n))
		else $error("outputs moved in power-down");
	a_hiz_kept: assert property (s_frozen2
		|-> (pin_oe_n & $past(pin_oe_n)) == $past(pin_oe_n))
		else $error("high-Z output driven in power-down");
	a_inputs_blocked: assert property (s_frozen2 |-> $stable(core_in))
		else $error("inputs passed in power-down");
	a_pd_release: assert property (freeze && !pd_req && isp_state == PSG_ISP_IDLE
		&& !isp_start |=> pwr_state == PSG_RESUME ##1 pin_out == $past(core_out))
		else $error("power-down not released");
	a_standby_exit: assert property (pwr_state == PSG_STANDBY && activity && !pd_req
		|=> pwr_state == PSG_RUN)
		else $error("standby not left on activity");
	a_abort_locks: assert property (s_abort_prog |=> isp_state == PSG_ISP_LOCKED
		##1 ($past(freeze) || (&pin_oe_n && jtag_tdo_oe_n)))
		else $error("interrupted programming not locked");
	a_keeper_hold: assert property (isp_state == PSG_ISP_PROG && keep_ok && !freeze
		|=> $stable(pin_out) && $stable(pin_oe_n))
		else $error("pin level not kept");
	a_gpio_jtag: assert property (!jtag_en && !freeze
		|=> core_in[`PSG_NPIN+2:`PSG_NPIN] == $past(jtag_q))
		else $error("test pins not given to user logic");
	a_port_needed: assert property (isp_start && !jtag_en |=> isp_state != PSG_ISP_PROG)
		else $error("programming without test port");
	a_erased_reset: assert property ($rose(aresetn) |-> !programmed)
		else $error("not erased after reset");
endmodule : psg_top
`default_nettype wire

// ---- psg_far.sv ----
// Purpose: Far-side model: power-down controller and test-port programmer.
// Assumes: Called from bench tasks; drives right after aclk rises.
// Notes:   The test clock stands low between bits.
`timescale 1ns/100ps
`default_nettype none
module psg_far (
	input  wire logic aclk,
	output logic      power_down_input_a,
	output logic      power_down_input_b,
	output logic      tck,
	output logic      tms,
	output logic      tdi
);
	// -------------------------------------------------------------
	// Power-down requests
	// -------------------------------------------------------------
	initial begin
		power_down_input_a = 1'b0;
		power_down_input_b = 1'b0;
		tck = 1'b0;
		tms = 1'b0;
		tdi = 1'b0;
	end

	// Either or both requests may be raised.
	task automatic pd_set(input logic a, input logic b);
		@(posedge aclk);
		power_down_input_a <= a;
		power_down_input_b <= b;
	endtask : pd_set

	// Waits 40 cycles; the resume window is still open when outputs are checked.
	task automatic pd_release();
		pd_set(1'b0, 1'b0);
		repeat (40) @(posedge aclk);
	endtask : pd_release

	// -------------------------------------------------------------
	// Test port
	// -------------------------------------------------------------
	// Slow bit so the pin synchroniser sees every level; data inverts once released.
	task automatic tap_bit(input logic m, input logic d);
		@(posedge aclk);
		tms <= m;
		tdi <= d;
		repeat (5) @(posedge aclk);
		tck <= 1'b1;
		repeat (5) @(posedge aclk);
		tck <= 1'b0;
		tdi <= ~d;
	endtask : tap_bit
endmodule : psg_far
`default_nettype wire

// ---- psg_top_bench.sv ----
// Purpose: Self-checking bench for the power-state and programming guard.
// Assumes: 40 MHz aclk, synchronous active-low reset.
// Notes:   Pins resolve from the design's enables and an outside level.
`include "psg_map.svh"
`timescale 1ns/100ps
`default_nettype none
module psg_top_bench import psg_pkg::*;;
	logic        aclk = 1'b0;
	logic        aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr, ext_pins, core_out, core_oe;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic        awready, wready, bvalid, arready, rvalid, core_jtag_out;
	logic [1:0]  bresp, rresp;
	logic [7:0]  pin_out, pin_oe_n;
	wire  [7:0]  pin_in;
	logic [10:0] core_in;
	logic        jtag_tdo, tdo_oe_n, core_hold, core_standby;
	logic [63:0] mc;
	logic        power_down_input_a, power_down_input_b, tck, tms, tdi;
	int          n_errors = 0;
	int          tests_run = 0;

	// -------------------------------------------------------------
	// Clock, pins and instances
	// -------------------------------------------------------------
	always #12.5 aclk = ~aclk;

	// A pin reads the design's drive where enabled, else the outside level.
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_pins);

	psg_far far (.aclk(aclk), .power_down_input_a(power_down_input_a),
		.power_down_input_b(power_down_input_b), .tck(tck), .tms(tms), .tdi(tdi));

	psg_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .power_down_input_a(power_down_input_a),
		.power_down_input_b(power_down_input_b), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe_n(pin_oe_n), .jtag_tck(tck), .jtag_tms(tms),
		.jtag_tdi(tdi), .jtag_tdo(jtag_tdo), .jtag_tdo_oe_n(tdo_oe_n),
		.core_out(core_out), .core_oe(core_oe), .core_jtag_out(core_jtag_out),
		.core_in(core_in), .core_hold(core_hold), .core_standby(core_standby),
		.mc_reduced_power(mc));

	// -------------------------------------------------------------
	// Shared tasks
	// -------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic settle();
		repeat (8) @(posedge aclk);
	endtask : settle

	// Address and data go out together; each drops when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		chk({bvalid, bresp}, {1'b1, er});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 50);
		rready <= 1'b0;
		chk(rdata, ed);
		chk({rvalid, rresp}, {1'b1, er});
	endtask : rd

	// -------------------------------------------------------------
	// Scenarios
	// -------------------------------------------------------------
	task automatic t_reset();
		rd(`PSG_OFF_CTRL, 32'h0000_0004, 2'h0);
		rd(`PSG_OFF_STATUS, 32'h0000_0000, 2'h0);
		rd(8'h14, 32'h0000_0000, 2'h2);
		wr(8'h14, 32'hffff_ffff, 2'h2);
		chk(mc, 64'h0);
		wr(`PSG_OFF_RPWR_LO, 32'h1234_5678, 2'h0);
		wr(`PSG_OFF_RPWR_HI, 32'h9abc_def0, 2'h0);
		settle();
		chk(mc, 64'h9abc_def0_1234_5678);
	endtask : t_reset

	// With the option off a request must leave the pins live.
	task automatic t_pd_off();
		far.pd_set(1'b1, 1'b0);
		settle();
		core_out <= 8'h5a;
		settle();
		chk(core_hold, 1'b0);
		chk(pin_out, 8'h5a);
		far.pd_release();
	endtask : t_pd_off

	// Low nibble enabled, high nibble floats at onset.
	task automatic t_pd(input logic sel);
		int n;
		wr(`PSG_OFF_CTRL, 32'h0000_0005, 2'h0);
		core_out <= 8'h3c;
		core_oe <= 8'h0f;
		ext_pins <= 8'h90;
		settle();
		far.pd_set(!sel, sel);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (core_hold !== 1'b1 && n < 12);
		chk(core_hold, 1'b1);
		core_out <= 8'hc3;
		core_oe <= 8'hff;
		ext_pins <= 8'h60;
		settle();
		chk(pin_out[3:0], 4'hc);
		chk(pin_oe_n, 8'hf0);
		chk(core_in[7:0], 8'h9c);
		far.pd_release();
		chk(core_hold, 1'b0);
		chk({pin_oe_n, pin_out, core_in}, {8'h00, 8'hc3, 11'h0c3});
	endtask : t_pd

	task automatic t_standby();
		int n;
		wr(`PSG_OFF_CTRL, 32'h0000_0006, 2'h0);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (core_standby !== 1'b1 && n < 40);
		chk(core_standby, 1'b1);
		chk(n >= 16, 1'b1);
		core_out <= 8'h3c;
		repeat (4) @(posedge aclk);
		chk(core_standby, 1'b0);
	endtask : t_standby

	task automatic t_prog();
		wr(`PSG_OFF_CTRL, 32'h0000_0004, 2'h0);
		wr(`PSG_OFF_ISP, 32'h1, 2'h0);
		settle();
		chk(pin_oe_n, 8'hff);
		wr(`PSG_OFF_ISP, 32'h4, 2'h0);
		settle();
		chk({pin_oe_n, tdo_oe_n}, 9'h1ff);
		rd(`PSG_OFF_STATUS, 32'h0000_0010, 2'h0);
		wr(`PSG_OFF_ISP, 32'h1, 2'h0);
		wr(`PSG_OFF_ISP, 32'h2, 2'h0);
		rd(`PSG_OFF_STATUS, 32'h0000_0020, 2'h0);
		wr(`PSG_OFF_CTRL, 32'h0000_000c, 2'h0);
		wr(`PSG_OFF_ISP, 32'h1, 2'h0);
		core_out <= 8'h55;
		settle();
		chk({pin_oe_n, pin_out}, {8'h00, 8'h3c});
		wr(`PSG_OFF_ISP, 32'h2, 2'h0);
		wr(`PSG_OFF_ISP, 32'h1, 2'h0);
		wr(`PSG_OFF_CTRL, 32'h0000_0000, 2'h0);
		rd(`PSG_OFF_STATUS, 32'h0000_0030, 2'h0);
	endtask : t_prog

	// Port off frees the test pins; port on bypasses data to the output.
	task automatic t_port();
		wr(`PSG_OFF_CTRL, 32'h0000_0000, 2'h0);
		core_jtag_out <= 1'b1;
		far.tap_bit(1'b1, 1'b1);
		settle();
		chk({core_in[10:8], jtag_tdo}, 4'b0101);
		wr(`PSG_OFF_CTRL, 32'h0000_0004, 2'h0);
		far.tap_bit(1'b0, 1'b0);
		settle();
		chk({core_in[10:8], jtag_tdo}, 4'b0000);
		far.tap_bit(1'b0, 1'b1);
		settle();
		chk(jtag_tdo, 1'b1);
	endtask : t_port

	// -------------------------------------------------------------
	// Verdict, watchdog and main sequence
	// -------------------------------------------------------------
	task automatic end_sim();
		if (n_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	// The whole run needs about 400 cycles; fifty times that is a hang.
	initial begin
		#500_000;
		n_errors++;
		end_sim();
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, core_jtag_out} = 7'h0;
		{awaddr, araddr, ext_pins, core_out, core_oe} = 40'h0;
		wdata = 32'h0;
		wstrb = 4'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		core_oe <= 8'hff;
		t_reset();
		t_pd_off();
		t_pd(1'b0);
		t_pd(1'b1);
		t_standby();
		t_prog();
		t_port();
		end_sim();
	end
endmodule : psg_top_bench
`default_nettype wire
